// >>> logic/tx_mac_pcs_config_port.sv
/*
  Transmit side of the MAC/PCS: frame check insertion or checking,
  inter-packet gap, lane marker insertion and the 16-bit config port.
  Assumes one clock for packets and config port, inputs synchronous to
  it, and a byte-wide packet source that honours the ready signal.
*/
`timescale 1ns/10ps
`include "txcfg_defines.svh"

// Overview of operation
// - Insertion on: compute and append frame check; off: send packets as given.
// - Ignore-check setting acts only while insertion is off.
// - Ignore on, insertion off: bad-check packet classed good.
// - Ignore off, insertion off: flag bad and stomped, send packet unchanged.
// - With ignore on, statistics count bad-check packets as if the check were correct.
// - Gap setting 8 to 12 is target minimum gap in bytes, default 12.
// - Gap setting 0 to 7 gives a minimum gap of terminate only, no idles.
// - Marker spacing setting is words from one marker to the next minus one, default 16383.
// - Each of twenty lanes holds its own 64-bit marker with own default.
// - Enable low: no access; enable high: select low reads, high writes.
// - Ready pulses when a write completes or read data is valid.
// - Read data is 16 bits, location chosen by 10-bit address.
module tx_mac_pcs_config_port (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CFG_ACCESS_ENABLE,
  input wire logic CFG_WRITE_SELECT,
  input wire logic [9:0] CFG_ADDRESS,
  input wire logic [15:0] CFG_WRITE_DATA,
  output logic [15:0] CFG_READ_DATA,
  output logic CFG_ACCESS_READY,
  input wire logic TX_IN_VALID,
  input wire logic [7:0] TX_IN_DATA,
  input wire logic TX_IN_SOP,
  input wire logic TX_IN_EOP,
  output logic TX_IN_READY,
  output logic TX_OUT_VALID,
  output logic [7:0] TX_OUT_DATA,
  output logic TX_OUT_CTRL,
  output logic MARKER_VALID,
  output logic [63:0] MARKER_DATA,
  output logic [4:0] MARKER_LANE,
  output logic STAT_TX_PACKET,
  output logic STAT_TX_GOOD,
  output logic STAT_TX_BAD,
  output logic STAT_TX_BAD_FCS,
  output logic STOMPED_CRC_FLAG,
  output logic FCS_INS_ENABLE,
  output logic IGNORE_FCS,
  output logic [3:0] IPG_VALUE,
  output logic [15:0] TX_MARKER_SPACING_M1
);

  // =====================================================
  // Reset image
  localparam txcfg_pkg::st_t RST_ST = '{
    state: txcfg_pkg::S_IDLE,
    ins: `RST_INS,
    ign: `RST_IGN,
    ipg: `RST_IPG,
    spacing: `RST_SPACING,
    mk: `RST_MK,
    crc: `CRC_INIT,
    default: '0
  };

  txcfg_pkg::st_t r;
  txcfg_pkg::st_t n;
  logic mark_now;
  logic accept;
  logic ins_now;
  logic [31:0] crc_base;
  logic [31:0] crc_new;
  logic [3:0] gap_target;
  logic hit_ctrl;
  logic hit_spacing;
  logic hit_marker;
  logic [9:0] mk_offset;
  logic [4:0] wr_lane;
  logic ign_eff;
  logic [7:0] fcs_byte;
  logic gap_done;

  // =====================================================
  // Frame check byte update
  function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] x;
    x = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  // =====================================================
  // Config readback
  function automatic logic [15:0] rd_word(input txcfg_pkg::st_t s, input logic [9:0] a);
    logic [9:0] idx;
    logic [15:0] w;
    idx = a - `A_MK_BASE;
    w = 16'h0000;
    if (a == `A_CTRL) begin
      w[`F_INS] = s.ins;
      w[`F_IGN] = s.ign;
      w[`F_IPG_HI:`F_IPG_LO] = s.ipg;
    end else if (a == `A_SPACING) begin
      w = s.spacing;
    end else if (a >= `A_MK_BASE && a < `A_MK_END) begin
      w = s.mk[idx[6:2]][{idx[1:0], 4'h0} +: 16];
    end
    return w;
  endfunction

  // =====================================================
  // Gap length target
  // Terminate only
  always_comb begin
    if (r.ipg < `IPG_MIN_VALID) begin
      gap_target = `GAP_TERM_ONLY;
    end else if (r.ipg > `IPG_MAX_VALID) begin
      gap_target = `IPG_MAX_VALID;
    end else begin
      gap_target = r.ipg;
    end
  end

  // =====================================================
  // Marker and packet handshake
  // Marker spacing count
  assign mark_now = (r.wcnt >= r.spacing);
  assign TX_IN_READY = (r.state == txcfg_pkg::S_DATA ||
                        r.state == txcfg_pkg::S_IDLE) && !mark_now;
  assign accept = TX_IN_READY && TX_IN_VALID &&
                  (r.state == txcfg_pkg::S_DATA || TX_IN_SOP);
  assign ins_now = (r.state == txcfg_pkg::S_IDLE) ? r.ins : r.pkt_ins;
  assign crc_base = (r.state == txcfg_pkg::S_IDLE) ? `CRC_INIT : r.crc;
  assign crc_new = crc8(crc_base, TX_IN_DATA);

  // =====================================================
  // Config port address decode
  assign hit_ctrl = (CFG_ADDRESS == `A_CTRL);
  assign hit_spacing = (CFG_ADDRESS == `A_SPACING);
  assign hit_marker = (CFG_ADDRESS >= `A_MK_BASE) && (CFG_ADDRESS < `A_MK_END);
  assign mk_offset = CFG_ADDRESS - `A_MK_BASE;
  assign wr_lane = mk_offset[6:2];

  // =====================================================
  // Packet end terms
  // Ignore only without insertion
  assign ign_eff = r.ign && !ins_now;
  assign fcs_byte = 8'(~r.crc >> {r.fcnt, 3'h0});
  assign gap_done = (4'(r.gcnt + 4'h1) >= gap_target);

  // =====================================================
  // Next state
  always_comb begin
    n = r;
    n.rdy = 1'b0;
    n.pkt = 1'b0;
    n.good = 1'b0;
    n.bad = 1'b0;
    n.bad_fcs = 1'b0;
    n.stomp = 1'b0;
    n.mk_valid = 1'b0;
    n.out_valid = 1'b0;
    n.out_ctrl = 1'b0;

    if (CFG_ACCESS_ENABLE) begin
      n.rdy = 1'b1;
      if (CFG_WRITE_SELECT) begin
        if (hit_ctrl) begin
          n.ins = CFG_WRITE_DATA[`F_INS];
          n.ign = CFG_WRITE_DATA[`F_IGN];
          n.ipg = CFG_WRITE_DATA[`F_IPG_HI:`F_IPG_LO];
        end else if (hit_spacing) begin
          n.spacing = CFG_WRITE_DATA;
        end else if (hit_marker) begin
          n.mk[wr_lane][{CFG_ADDRESS[1:0], 4'h0} +: 16] = CFG_WRITE_DATA;
        end
      end else begin
        n.rd_data = rd_word(r, CFG_ADDRESS);
      end
    end

    if (mark_now) begin
      n.mk_valid = 1'b1;
      n.mk_data = r.mk[r.lane];
      n.mk_lane = r.lane;
      n.wcnt = 16'h0000;
      n.lane = (r.lane == `LANE_LAST) ? 5'h00 : 5'(r.lane + 5'h01);
    end else begin
      n.wcnt = 16'(r.wcnt + 16'h0001);
      unique case (r.state)
        txcfg_pkg::S_IDLE, txcfg_pkg::S_DATA: begin
          if (r.state == txcfg_pkg::S_IDLE) begin
            n.out_valid = 1'b1;
            n.out_ctrl = 1'b1;
            n.out_data = `CW_IDLE;
          end
          if (accept) begin
            n.state = txcfg_pkg::S_DATA;
            n.pkt_ins = ins_now;
            n.crc = crc_new;
            n.out_valid = 1'b1;
            n.out_ctrl = 1'b0;
            n.out_data = TX_IN_DATA;
            if (TX_IN_EOP) begin
              if (ins_now) begin
                n.state = txcfg_pkg::S_FCS;
                n.fcnt = 2'h0;
              end else begin
                n.state = txcfg_pkg::S_GAP;
                n.gcnt = 4'h0;
                n.pkt = 1'b1;
                if (crc_new == `CRC_RESID || ign_eff) begin
                  n.good = 1'b1;
                end else begin
                  n.bad = 1'b1;
                  n.bad_fcs = 1'b1;
                  n.stomp = 1'b1;
                end
              end
            end
          end
        end
        txcfg_pkg::S_FCS: begin
          n.out_valid = 1'b1;
          n.out_data = fcs_byte;
          n.fcnt = 2'(r.fcnt + 2'h1);
          if (r.fcnt == `FCS_LAST) begin
            n.state = txcfg_pkg::S_GAP;
            n.gcnt = 4'h0;
            n.pkt = 1'b1;
            n.good = 1'b1;
          end
        end
        txcfg_pkg::S_GAP: begin
          n.out_valid = 1'b1;
          n.out_ctrl = 1'b1;
          n.out_data = (r.gcnt == 4'h0) ? `CW_TERM : `CW_IDLE;
          n.gcnt = 4'(r.gcnt + 4'h1);
          if (gap_done) begin
            n.state = txcfg_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

  // =====================================================
  // State register
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      r <= RST_ST;
    end else begin
      r <= n;
    end
  end

  // =====================================================
  // Config port outputs
  assign CFG_READ_DATA = r.rd_data;
  assign CFG_ACCESS_READY = r.rdy;

  // =====================================================
  // Stream and marker outputs
  assign TX_OUT_VALID = r.out_valid;
  assign TX_OUT_DATA = r.out_data;
  assign TX_OUT_CTRL = r.out_ctrl;
  assign MARKER_VALID = r.mk_valid;
  assign MARKER_DATA = r.mk_data;
  assign MARKER_LANE = r.mk_lane;

  // =====================================================
  // Status pulses and settings
  assign STAT_TX_PACKET = r.pkt;
  assign STAT_TX_GOOD = r.good;
  assign STAT_TX_BAD = r.bad;
  assign STAT_TX_BAD_FCS = r.bad_fcs;
  assign STOMPED_CRC_FLAG = r.stomp;
  assign FCS_INS_ENABLE = r.ins;
  assign IGNORE_FCS = r.ign;
  assign IPG_VALUE = r.ipg;
  assign TX_MARKER_SPACING_M1 = r.spacing;

endmodule

// >>> logic/txcfg_defines.svh
/*
  Constants of the transmit configuration block: config port map,
  reset values, code words and frame check constants.
  Assumes it is included by its bare name wherever the values are used.
*/
`ifndef TXCFG_DEFINES_SVH
`define TXCFG_DEFINES_SVH

// =====================================================
// Config port map
`define A_CTRL 10'h000
`define A_SPACING 10'h001
`define A_MK_BASE 10'h010
`define A_MK_END 10'h060

// =====================================================
// Control word fields
`define F_INS 0
`define F_IGN 1
`define F_IPG_LO 4
`define F_IPG_HI 7

// =====================================================
// Reset values
`define RST_INS 1'b1
`define RST_IGN 1'b0
`define RST_IPG 4'hC
`define RST_SPACING 16'h3FFF
`define RST_MK { \
  64'hC0F0E5003F0F1A00, 64'h5F662A00A099D500, 64'hADD6B70052294800, \
  64'hC4314C003BCEB300, 64'h3536CD00CAC93200, 64'h83C7CA007C383500, \
  64'h1AF8BD00E5074200, 64'h5CB9B200A3464D00, 64'hB9915500466EAA00, \
  64'hFD6C990002936600, 64'h68C9FB0097360400, 64'hA02476005FDB8900, \
  64'h7B45660084BA9900, 64'h9A4A260065B5D900, 64'hDD14C20022EB3D00, \
  64'hF50709000AF8F600, 64'h4D957B00B26A8400, 64'h594BE800A6B41700, \
  64'h9D718E00628E7100, 64'hC16821003E97DE00}

// =====================================================
// Gap and lane figures
`define IPG_MIN_VALID 4'h8
`define IPG_MAX_VALID 4'hC
`define GAP_TERM_ONLY 4'h1
`define LANES 5'h14
`define LANE_LAST 5'h13

// =====================================================
// Code words and frame check
`define CW_IDLE 8'h07
`define CW_TERM 8'hFD
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY 32'hEDB88320
`define CRC_RESID 32'hDEBB20E3
`define FCS_LAST 2'h3

`endif

// >>> logic/txcfg_pkg.sv
/*
  Types of the transmit configuration block: state codes and the
  packed state record. Assumes nothing of its surroundings.
*/
package txcfg_pkg;

  // =====================================================
  // Transmit states
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_DATA = 4'h2,
    S_FCS = 4'h4,
    S_GAP = 4'h8
  } state_t;

  // =====================================================
  // Whole module state
  typedef struct packed {
    state_t state;
    logic ins;
    logic ign;
    logic [3:0] ipg;
    logic [15:0] spacing;
    logic [19:0][63:0] mk;
    logic pkt_ins;
    logic [31:0] crc;
    logic [1:0] fcnt;
    logic [3:0] gcnt;
    logic [15:0] wcnt;
    logic [4:0] lane;
    logic out_valid;
    logic [7:0] out_data;
    logic out_ctrl;
    logic mk_valid;
    logic [63:0] mk_data;
    logic [4:0] mk_lane;
    logic [15:0] rd_data;
    logic rdy;
    logic pkt;
    logic good;
    logic bad;
    logic bad_fcs;
    logic stomp;
  } st_t;

endpackage

// >>> testbench/txcfg_monitor.sv
/*
  Port checker of the transmit config block.
  Assumes it is bound to tx_mac_pcs_config_port, one clock.
*/
`timescale 1ns/10ps
`include "txcfg_defines.svh"
module txcfg_monitor (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CFG_ACCESS_ENABLE,
  input wire logic CFG_WRITE_SELECT,
  input wire logic [9:0] CFG_ADDRESS,
  input wire logic [15:0] CFG_WRITE_DATA,
  input wire logic [15:0] CFG_READ_DATA,
  input wire logic CFG_ACCESS_READY,
  input wire logic TX_OUT_VALID,
  input wire logic MARKER_VALID,
  input wire logic STAT_TX_PACKET,
  input wire logic STAT_TX_GOOD,
  input wire logic STAT_TX_BAD,
  input wire logic STAT_TX_BAD_FCS,
  input wire logic STOMPED_CRC_FLAG,
  input wire logic FCS_INS_ENABLE,
  input wire logic IGNORE_FCS,
  input wire logic [15:0] TX_MARKER_SPACING_M1
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // =====================================================
  // Config port
  a_ready_next: assert property (CFG_ACCESS_ENABLE |=> CFG_ACCESS_READY)
    else $error("ready missing");
  a_ready_cause: assert property (CFG_ACCESS_READY |-> $past(CFG_ACCESS_ENABLE))
    else $error("ready without access");
  a_read_hold: assert property ((!CFG_ACCESS_ENABLE || CFG_WRITE_SELECT)
    |=> $stable(CFG_READ_DATA)) else $error("read data moved");
  a_spacing_write: assert property (CFG_ACCESS_ENABLE && CFG_WRITE_SELECT
    && CFG_ADDRESS == `A_SPACING |=> TX_MARKER_SPACING_M1 == $past(CFG_WRITE_DATA))
    else $error("spacing not written");
  // =====================================================
  // Packet status and marker pause
  a_stomp_pair: assert property (STAT_TX_BAD_FCS |-> STOMPED_CRC_FLAG && STAT_TX_BAD)
    else $error("bad check flags apart");
  a_stomp_only: assert property (STOMPED_CRC_FLAG |-> STAT_TX_BAD_FCS)
    else $error("stray stomp");
  a_bad_cause: assert property (STAT_TX_BAD_FCS |-> !FCS_INS_ENABLE && !IGNORE_FCS)
    else $error("bad check flag in wrong mode");
  a_one_bin: assert property (STAT_TX_PACKET |-> STAT_TX_GOOD ^ STAT_TX_BAD)
    else $error("packet binned twice or never");
  a_bin_counted: assert property (STAT_TX_GOOD || STAT_TX_BAD |-> STAT_TX_PACKET)
    else $error("bin without packet");
  a_ins_good: assert property (STAT_TX_PACKET && FCS_INS_ENABLE |-> STAT_TX_GOOD)
    else $error("inserted check not good");
  a_marker_pause: assert property (MARKER_VALID |-> !TX_OUT_VALID)
    else $error("byte during marker");
endmodule

bind tx_mac_pcs_config_port txcfg_monitor txcfg_monitor_inst (.MCLK(MCLK), .RST_B(RST_B),
  .CFG_ACCESS_ENABLE(CFG_ACCESS_ENABLE), .CFG_WRITE_SELECT(CFG_WRITE_SELECT),
  .CFG_ADDRESS(CFG_ADDRESS), .CFG_WRITE_DATA(CFG_WRITE_DATA), .CFG_READ_DATA(CFG_READ_DATA),
  .CFG_ACCESS_READY(CFG_ACCESS_READY), .TX_OUT_VALID(TX_OUT_VALID),
  .MARKER_VALID(MARKER_VALID), .STAT_TX_PACKET(STAT_TX_PACKET), .STAT_TX_GOOD(STAT_TX_GOOD),
  .STAT_TX_BAD(STAT_TX_BAD), .STAT_TX_BAD_FCS(STAT_TX_BAD_FCS),
  .STOMPED_CRC_FLAG(STOMPED_CRC_FLAG), .FCS_INS_ENABLE(FCS_INS_ENABLE),
  .IGNORE_FCS(IGNORE_FCS), .TX_MARKER_SPACING_M1(TX_MARKER_SPACING_M1));

// >>> testbench/pkt_src.sv
/*
  Packet source standing for the user logic on the packet side.
  Assumes a ready signal driven by the block, sampled at rising edges.
*/
`timescale 1ns/10ps
module pkt_src (
  input wire logic clk,
  input wire logic ready,
  output logic valid,
  output logic [7:0] data,
  output logic sop,
  output logic eop
);
  logic [7:0] last[$];
  initial begin
    valid = 1'b0;
    data = 8'h00;
    sop = 1'b0;
    eop = 1'b0;
  end
  // =====================================================
  // Reflected frame check, low byte sent first
  function automatic logic [31:0] crc(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (q[i]) begin
      c = c ^ {24'h000000, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction
  // =====================================================
  // Six-byte packet, check bytes appended and spoilt on request
  task automatic send(input logic f, input logic b);
    logic [31:0] c;
    last.delete();
    for (int i = 0; i < 6; i++)
      last.push_back(8'h51 + 8'(i));
    c = crc(last);
    for (int i = 0; i < 4 && f; i++)
      last.push_back(c[8 * i +: 8] ^ {7'h00, b});
    foreach (last[i]) begin
      @(negedge clk);
      valid = 1'b1;
      data = last[i];
      sop = (i == 0);
      eop = (i == last.size() - 1);
      do @(posedge clk); while (ready !== 1'b1);
    end
  endtask
  task automatic stop();
    @(negedge clk);
    valid = 1'b0;
    data = ~data;
    sop = 1'b0;
    eop = 1'b0;
  endtask
endmodule

// >>> testbench/tb.sv
/*
  Self-checking bench of the transmit config block.
  Assumes the packet source model and the bound port checker.
*/
`timescale 1ns/10ps
`include "txcfg_defines.svh"
module tb;
  logic mclk = 1'b0, rst_b = 1'b0, en = 1'b0, we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [15:0] wd = 16'h0000, rdat, spc;
  logic rdy, iv, sop, eop, irdy, ov, octl, mv, ins, ign;
  logic [7:0] idat, od;
  logic [63:0] md;
  logic [4:0] ml;
  wire [4:0] st;
  logic [7:0] term = 8'h00;
  logic [4:0] seen = 5'h00;
  logic [3:0] ipg;
  logic [7:0] oq[$], eq[$];
  logic [63:0] mk[2] = '{64'hC16821003E97DE00, 64'h9D718E00628E7100};
  int num_errors = 0, samples_checked = 0, cyc = 0, run = 0, gap = 0;

  // Config port shares MCLK, no port clock to tie off
  tx_mac_pcs_config_port tx_mac_pcs_config_port_inst (
    .MCLK(mclk), .RST_B(rst_b), .CFG_ACCESS_ENABLE(en), .CFG_WRITE_SELECT(we),
    .CFG_ADDRESS(adr), .CFG_WRITE_DATA(wd), .CFG_READ_DATA(rdat), .CFG_ACCESS_READY(rdy),
    .TX_IN_VALID(iv), .TX_IN_DATA(idat), .TX_IN_SOP(sop), .TX_IN_EOP(eop), .TX_IN_READY(irdy),
    .TX_OUT_VALID(ov), .TX_OUT_DATA(od), .TX_OUT_CTRL(octl), .MARKER_VALID(mv),
    .MARKER_DATA(md), .MARKER_LANE(ml), .STAT_TX_PACKET(st[0]), .STAT_TX_GOOD(st[1]),
    .STAT_TX_BAD(st[2]), .STAT_TX_BAD_FCS(st[3]), .STOMPED_CRC_FLAG(st[4]),
    .FCS_INS_ENABLE(ins), .IGNORE_FCS(ign), .IPG_VALUE(ipg), .TX_MARKER_SPACING_M1(spc));
  pkt_src pkt_src_inst (.clk(mclk), .ready(irdy), .valid(iv), .data(idat), .sop(sop), .eop(eop));

  // =====================================================
  // Clock, output capture and timeout
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    seen <= seen | st;
    if (ov && octl) run <= run + 1;
    if (ov && octl && run == 0) term <= od;
    if (ov && !octl) begin
      oq.push_back(od);
      if (run > 0) gap <= run;
      run <= 0;
    end
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  // =====================================================
  // Access and compare tasks
  task automatic chk(input logic [71:0] s, input logic [71:0] e, input string w);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", w, e, s);
    end
  endtask
  // One-cycle request with data, ready checked one cycle later
  task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d);
    @(negedge mclk);
    en = 1'b1;
    we = w;
    adr = a;
    wd = d;
    @(negedge mclk);
    en = 1'b0;
    we = 1'b0;
    wd = ~d;
    chk(rdy, 1'b1, "ready");
  endtask
  task automatic rdc(input logic [9:0] a, input logic [15:0] e, input string w);
    acc(1'b0, a, 16'h0000);
    chk(rdat, e, w);
  endtask
  task automatic pair(input logic f, input logic b, input logic [4:0] es, input int eg);
    logic [31:0] c;
    @(negedge mclk);
    seen = 5'h00;
    oq.delete();
    repeat (2) pkt_src_inst.send(f, b);
    pkt_src_inst.stop();
    repeat (40) @(negedge mclk);
    eq = pkt_src_inst.last;
    c = pkt_src_inst.crc(eq);
    for (int i = 0; i < 4 && !f; i++)
      eq.push_back(c[8 * i +: 8]);
    chk(oq.size(), 2 * eq.size(), "length");
    foreach (oq[i]) chk(oq[i], eq[i % eq.size()], "byte");
    chk(seen, es, "stats");
    chk(gap, eg, "gap");
    chk(term, `CW_TERM, "terminate");
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // =====================================================
  // Test sequence
  initial begin
    int k;
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    chk({ins, ign, ipg, spc}, {1'b1, 1'b0, 4'hC, 16'h3FFF}, "defaults");
    rdc(`A_SPACING, 16'h3FFF, "spacing");
    for (int l = 0; l < 2; l++)
      for (int w = 0; w < 4; w++)
        rdc(`A_MK_BASE + 10'(4 * l + w), mk[l][16 * w +: 16], "marker");
    rdc(10'h3FF, 16'h0000, "unmapped");
    acc(1'b1, `A_CTRL, 16'h0081);
    rdc(`A_CTRL, 16'h0081, "ctrl");
    chk({ins, ign, ipg}, 6'h28, "settings");
    pair(1'b0, 1'b0, 5'h03, 8);
    acc(1'b1, `A_CTRL, 16'h0031);
    pair(1'b0, 1'b0, 5'h03, 1);
    acc(1'b1, `A_CTRL, 16'h0080);
    pair(1'b1, 1'b1, 5'h1D, 8);
    acc(1'b1, `A_CTRL, 16'h0082);
    pair(1'b1, 1'b1, 5'h03, 8);
    acc(1'b1, `A_CTRL, 16'h0083);
    pair(1'b0, 1'b0, 5'h03, 8);
    acc(1'b1, `A_SPACING, 16'h0010);
    for (k = 0; k < 40 && mv !== 1'b1; k++) @(negedge mclk);
    chk({ml, md}, {5'h00, mk[0]}, "marker0");
    @(negedge mclk);
    for (k = 1; k < 40 && mv !== 1'b1; k++) @(negedge mclk);
    chk(k, 17, "interval");
    chk({ml, md}, {5'h01, mk[1]}, "marker1");
    print_verdict();
  end
endmodule
